// file: xpid_pkg.sv
// Constants and carriers for the XRAM page select and device identity bank.
// Assumes a core that issues byte-wide special-function register accesses.
package xpid_pkg;

  // ==========================================================================
  // Register addresses and pages
  localparam logic [7:0] XPID_ADDR_PAGE_SEL = 8'hAA;
  localparam logic [7:0] XPID_ADDR_DERIV_SER0 = 8'hAB;
  localparam logic [7:0] XPID_ADDR_REV_SER1 = 8'hAC;
  localparam logic [7:0] XPID_ADDR_SER2 = 8'hAD;
  localparam logic [7:0] XPID_ADDR_SER3 = 8'hAE;
  localparam logic [7:0] XPID_PAGE_BASE = 8'h00;
  localparam logic [7:0] XPID_PAGE_ALT = 8'h0F;

  // ==========================================================================
  // Field layout and reset values
  localparam int XPID_PAGE_FIELD_LSB = 0;
  localparam int XPID_PAGE_FIELD_W = 2;
  localparam logic [1:0] XPID_PAGE_FIELD_RST = 2'h0;
  localparam int XPID_XADDR_W = 16;
  localparam int XPID_XRAM_IDX_W = 10;
  localparam logic [7:0] XPID_RD_DEFAULT = 8'h00;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
  } xpid_sfr_req_t;

  typedef struct packed {
    logic        req;
    logic        wide;
    logic [15:0] dptr;
    logic [7:0]  low;
  } xpid_xmove_t;

endpackage

// file: xpid_sfr_decode.sv
// Decodes a paged register access into one-hot register selects.
// Assumes the request is stable for the cycle in which it is presented.
`timescale 1ns/100ps
`default_nettype none
module xpid_sfr_decode
  import xpid_pkg::*;
(
  input wire xpid_sfr_req_t i_req,
  output logic o_sel_page,
  output logic o_sel_deriv,
  output logic o_sel_rev,
  output logic [3:0] o_sel_sn
);
  logic pg0;
  logic pgf;

  always_comb
  begin
    pg0 = (i_req.page == XPID_PAGE_BASE);
    pgf = (i_req.page == XPID_PAGE_ALT);
    o_sel_page = (i_req.addr == XPID_ADDR_PAGE_SEL);
    o_sel_deriv = pg0 && (i_req.addr == XPID_ADDR_DERIV_SER0);
    o_sel_rev = pg0 && (i_req.addr == XPID_ADDR_REV_SER1);
    o_sel_sn[0] = pgf && (i_req.addr == XPID_ADDR_DERIV_SER0);
    o_sel_sn[1] = pgf && (i_req.addr == XPID_ADDR_REV_SER1);
    o_sel_sn[2] = pgf && (i_req.addr == XPID_ADDR_SER2);
    o_sel_sn[3] = pgf && (i_req.addr == XPID_ADDR_SER3);
  end
endmodule
`default_nettype wire

// file: xpid_xaddr.sv
// Forms the XRAM index of an external data move.
// Assumes the page select value comes from a register on the same clock.
`timescale 1ns/100ps
`default_nettype none
module xpid_xaddr
  import xpid_pkg::*;
(
  input wire xpid_xmove_t i_move,
  input wire logic [1:0] i_page_sel,
  output logic [15:0] o_full_addr,
  output logic [9:0] o_index
);
  always_comb
  begin
    if (i_move.wide)
    begin
      o_full_addr = i_move.dptr;
    end
    else
    begin
      o_full_addr = {6'h00, i_page_sel, i_move.low};
    end
    o_index = o_full_addr[XPID_XRAM_IDX_W-1:0];
  end
endmodule
`default_nettype wire

// file: xpid_regs.sv
// Register bank: XRAM page select, derivative and revision codes, serial number.
// Assumes the core presents rd/wr pulses with address and register page.
`timescale 1ns/100ps
`default_nettype none

module xpid_regs
  import xpid_pkg::*;
#(
  parameter logic [7:0] DERIV_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] REV_CODE = 8'h3C, // Arbitrary value
  parameter logic [31:0] SERIAL_NUM = 32'h1234_5678 // Arbitrary value
)
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire xpid_sfr_req_t i_sfr,
  output logic [7:0] o_rdata,
  output logic o_hit,
  input wire xpid_xmove_t i_move,
  output logic [15:0] o_xaddr,
  output logic [9:0] o_xram_index,
  output logic o_xram_req
);

  // ==========================================================================
  // Elaboration checks on the shared layout constants
  if (XPID_PAGE_FIELD_LSB + XPID_PAGE_FIELD_W > 8)
  begin : g_chk_field
    $error("page field does not fit in a register byte");
  end
  if (XPID_PAGE_FIELD_W + 8 > XPID_XADDR_W)
  begin : g_chk_xaddr
    $error("page field and low byte exceed the move address");
  end
  if (XPID_XRAM_IDX_W > XPID_XADDR_W)
  begin : g_chk_idx_hi
    $error("XRAM index wider than the move address");
  end
  if (XPID_XRAM_IDX_W < XPID_PAGE_FIELD_W + 8)
  begin : g_chk_idx_lo
    $error("XRAM index too narrow for every page");
  end

  // ==========================================================================
  // Decode
  logic sel_page;
  logic sel_deriv;
  logic sel_rev;
  logic [3:0] sel_sn;

  xpid_sfr_decode u_dec
  (
    .i_req(i_sfr),
    .o_sel_page(sel_page),
    .o_sel_deriv(sel_deriv),
    .o_sel_rev(sel_rev),
    .o_sel_sn(sel_sn)
  );

  // ==========================================================================
  // Access qualifiers
  logic wr_page;
  logic [3:0] wr_sn;
  logic rd_any;

  // Page select decodes on every register page; the rest only on pages 0 and F
  always_comb
  begin
    wr_page = i_sfr.wr && sel_page;
    wr_sn = i_sfr.wr ? sel_sn : 4'h0;
    rd_any = i_sfr.rd && (sel_page || sel_deriv || sel_rev || (|sel_sn));
  end

  // ==========================================================================
  // Page select and serial storage
  logic [1:0] page_field_q;
  logic [1:0] page_field_d;
  logic [7:0] sn_q [4];
  logic [7:0] sn_d [4];
  logic [3:0] sn_load_q;
  logic [3:0] sn_load_d;

  always_comb
  begin
    page_field_d = page_field_q;
    // Upper data bits are dropped here, so they can never read back
    if (wr_page)
    begin
      page_field_d = i_sfr.wdata[XPID_PAGE_FIELD_LSB +: XPID_PAGE_FIELD_W];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      page_field_q <= XPID_PAGE_FIELD_RST;
    end
    else
    begin
      page_field_q <= page_field_d;
    end
  end

  // Factory value loads once after reset release; firmware may overwrite it
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sn
      always_comb
      begin
        sn_d[g] = sn_q[g];
        sn_load_d[g] = 1'b1;
        if (!sn_load_q[g])
        begin
          sn_d[g] = SERIAL_NUM[8*g +: 8];
        end
        else if (wr_sn[g])
        begin
          sn_d[g] = i_sfr.wdata;
        end
      end

      always_ff @(posedge i_core_clk or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          sn_q[g] <= 8'h00;
          sn_load_q[g] <= 1'b0;
        end
        else
        begin
          sn_q[g] <= sn_d[g];
          sn_load_q[g] <= sn_load_d[g];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Read data, registered
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic hit_d;
  logic hit_q;

  // Unmapped address or page reads zero with no hit
  // A write to the page field in the same cycle is seen only by the next read
  always_comb
  begin
    rdata_d = XPID_RD_DEFAULT;
    hit_d = 1'b0;
    if (i_sfr.rd)
    begin
      hit_d = rd_any;
      if (sel_page)
      begin
        rdata_d = {6'h00, page_field_q};
      end
      else if (sel_deriv)
      begin
        rdata_d = DERIV_CODE;
      end
      else if (sel_rev)
      begin
        rdata_d = REV_CODE;
      end
      else if (sel_sn[0])
      begin
        rdata_d = sn_q[0];
      end
      else if (sel_sn[1])
      begin
        rdata_d = sn_q[1];
      end
      else if (sel_sn[2])
      begin
        rdata_d = sn_q[2];
      end
      else if (sel_sn[3])
      begin
        rdata_d = sn_q[3];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rdata_q <= XPID_RD_DEFAULT;
      hit_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_hit = hit_q;

  // ==========================================================================
  // External data move address, registered
  logic [15:0] xaddr_c;
  logic [9:0] xidx_c;
  logic [15:0] xaddr_q;
  logic [15:0] xaddr_d;
  logic [9:0] xidx_q;
  logic [9:0] xidx_d;
  logic xreq_q;
  logic xreq_d;

  xpid_xaddr u_xa
  (
    .i_move(i_move),
    .i_page_sel(page_field_q),
    .o_full_addr(xaddr_c),
    .o_index(xidx_c)
  );

  // Address outputs hold between moves so the XRAM port sees no idle changes
  always_comb
  begin
    xaddr_d = xaddr_q;
    xidx_d = xidx_q;
    xreq_d = i_move.req;
    if (i_move.req)
    begin
      xaddr_d = xaddr_c;
      xidx_d = xidx_c;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      xaddr_q <= 16'h0000;
      xidx_q <= 10'h000;
      xreq_q <= 1'b0;
    end
    else
    begin
      xaddr_q <= xaddr_d;
      xidx_q <= xidx_d;
      xreq_q <= xreq_d;
    end
  end

  assign o_xaddr = xaddr_q;
  assign o_xram_index = xidx_q;
  assign o_xram_req = xreq_q;

endmodule
`default_nettype wire

// file: xpid_properties.sv
// Checker for the page select and identity register bank.
// Bound to xpid_regs; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module xpid_properties
  import xpid_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire xpid_sfr_req_t i_sfr,
  input wire logic [7:0] o_rdata,
  input wire logic o_hit,
  input wire xpid_xmove_t i_move,
  input wire logic [15:0] o_xaddr,
  input wire logic [9:0] o_xram_index,
  input wire logic o_xram_req
);
  // ==========================================================================
  // Shadow of the page field
  logic [1:0] pg_q;
  logic [1:0] pg_d;
  logic rd_sn;
  assign pg_d = (i_sfr.wr && i_sfr.addr == XPID_ADDR_PAGE_SEL) ? i_sfr.wdata[1:0] : pg_q;
  assign rd_sn = i_sfr.rd && i_sfr.addr inside {[8'hAB:8'hAE]};
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn) pg_q <= 2'h0;
    else pg_q <= pg_d;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================================
  // Properties
  chk_short_move: assert property (
    i_move.req && !i_move.wide |=>
      o_xram_req && o_xaddr == {6'h00, $past(pg_q), $past(i_move.low)})
    else $error("short move address wrong");
  chk_short_index: assert property (
    i_move.req && !i_move.wide |=> o_xram_index == {$past(pg_q), $past(i_move.low)})
    else $error("short move index not page and low byte");
  chk_wide_move: assert property (
    i_move.req && i_move.wide |=> o_xram_index == $past(i_move.dptr[9:0]))
    else $error("wide move index wrong");
  chk_index_low: assert property (o_xram_index == o_xaddr[9:0])
    else $error("index not low address bits");
  chk_upper_zero: assert property (
    i_sfr.rd && i_sfr.addr == XPID_ADDR_PAGE_SEL |=> o_hit && o_rdata[7:2] == 6'h00)
    else $error("page select upper bits not zero");
  chk_page_readback: assert property (
    i_sfr.rd && i_sfr.addr == XPID_ADDR_PAGE_SEL |=> o_rdata[1:0] == $past(pg_q))
    else $error("page select readback wrong");
  chk_unpaged_miss: assert property (
    rd_sn && !(i_sfr.page inside {8'h00, 8'h0F}) |=> !o_hit && o_rdata == 8'h00)
    else $error("unimplemented page answered");
  chk_base_ident: assert property (
    i_sfr.rd && i_sfr.page == 8'h00 && i_sfr.addr inside {8'hAB, 8'hAC} |=> o_hit)
    else $error("identity code missing on page 0");
  chk_alt_serial: assert property (
    rd_sn && i_sfr.page == 8'h0F |=> o_hit)
    else $error("serial byte missing on page F");
endmodule
`default_nettype wire

// file: xpid_core_model.sv
// Processor core model issuing paged register accesses and moves.
// Tasks are called from the bench at a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module xpid_core_model
  import xpid_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_hit,
  input wire logic [15:0] i_xaddr,
  input wire logic [9:0] i_xidx,
  input wire logic i_xreq,
  output var xpid_sfr_req_t o_sfr,
  output var xpid_xmove_t o_move
);
  initial o_sfr <= '0;
  initial o_move <= '0;
  task automatic acc(input logic w, input logic [7:0] a, p, d, output logic [8:0] r);
    o_sfr <= '{rd: !w, wr: w, addr: a, page: p, wdata: d};
    @(posedge i_core_clk);
    o_sfr <= '0;
    @(posedge i_core_clk);
    r = {i_hit, i_rdata};
  endtask
  task automatic mv(input logic w, input logic [15:0] dp, input logic [7:0] lo,
                    output logic [26:0] r);
    o_move <= '{req: 1'b1, wide: w, dptr: dp, low: lo};
    @(posedge i_core_clk);
    o_move <= '0;
    @(posedge i_core_clk);
    r = {i_xreq, i_xidx, i_xaddr};
  endtask
endmodule
`default_nettype wire

// file: xpid_regs_bench.sv
// Self-checking bench for the page select and identity bank.
// Drives the bank through the core model; checker bound at the foot.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module xpid_regs_bench
  import xpid_pkg::*;
;
  // Arbitrary identity values
  localparam logic [7:0] DV = 8'hC3;
  localparam logic [7:0] RV = 8'h96;
  localparam logic [31:0] SN = 32'hA1B2_C3D4;
  logic clk, rstn, hit, xreq;
  xpid_sfr_req_t sfr;
  xpid_xmove_t mv;
  logic [7:0] rdata;
  logic [15:0] xaddr;
  logic [9:0] xidx;
  int bad_count, num_checks, cyc;
  logic [1:0] pg;
  logic [7:0] sn [4];
  xpid_regs #(.DERIV_CODE(DV), .REV_CODE(RV), .SERIAL_NUM(SN)) DUT (.i_core_clk(clk),
    .i_rstn(rstn), .i_sfr(sfr), .o_rdata(rdata), .o_hit(hit), .i_move(mv),
    .o_xaddr(xaddr), .o_xram_index(xidx), .o_xram_req(xreq));
  xpid_core_model core (.i_core_clk(clk), .i_rdata(rdata), .i_hit(hit), .i_xaddr(xaddr),
    .i_xidx(xidx), .i_xreq(xreq), .o_sfr(sfr), .o_move(mv));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================================
  // Expectations
  function automatic logic [8:0] exp_rd(logic [7:0] a, p);
    if (a == XPID_ADDR_PAGE_SEL) return {1'b1, 6'h00, pg};
    if (p == XPID_PAGE_BASE && a == XPID_ADDR_DERIV_SER0) return {1'b1, DV};
    if (p == XPID_PAGE_BASE && a == XPID_ADDR_REV_SER1) return {1'b1, RV};
    if (p == XPID_PAGE_ALT && a inside {[8'hAB:8'hAE]}) return {1'b1, sn[a - 8'hAB]};
    return 9'h000;
  endfunction
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    pg = 2'h0;
    for (int k = 0; k < 4; k++) sn[k] = SN[8*k +: 8];
    repeat (2) @(posedge clk);
  endtask
  task automatic rw(input logic w, input logic [7:0] a, p, d);
    logic [8:0] e, r;
    e = w ? 9'h000 : exp_rd(a, p);
    core.acc(w, a, p, d, r);
    `CHK(r, e)
    if (w && a == XPID_ADDR_PAGE_SEL) pg = d[1:0];
    if (w && p == XPID_PAGE_ALT && a inside {[8'hAB:8'hAE]}) sn[a - 8'hAB] = d;
  endtask
  task automatic move(input logic w, input logic [15:0] dp, input logic [7:0] lo);
    logic [26:0] e, r;
    e = w ? {1'b1, dp[9:0], dp} : {1'b1, pg, lo, 6'h00, pg, lo};
    core.mv(w, dp, lo, r);
    `CHK(r, e)
  endtask
  // Ceiling well above the expected run of about 1260 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  // ==========================================================================
  // Tests
  initial
  begin
    logic [7:0] p;
    void'($urandom(79063));
    do_reset();
    rw(0, 8'hAA, 8'h00, 8'h00);
    rw(1, 8'hAA, 8'h0F, 8'hFF);
    rw(0, 8'hAA, 8'h0F, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      p = (i < 4) ? XPID_PAGE_BASE : (i < 8) ? XPID_PAGE_ALT : 8'h03;
      rw(0, 8'hAB + 8'(i % 4), p, 8'h00);
    end
    rw(1, 8'hAB, 8'h00, 8'hFF);
    rw(0, 8'hAB, 8'h00, 8'h00);
    rw(1, 8'hAD, 8'h0F, 8'h5E);
    rw(0, 8'hAD, 8'h0F, 8'h00);
    $display("test registers done");
    rw(1, 8'hAA, 8'h00, 8'h02);
    move(0, 16'hFFFF, 8'h34);
    move(1, 16'hFC05, 8'h00);
    $display("test moves done");
    repeat (300)
    begin
      p = 8'($urandom);
      if (p[7]) p = XPID_PAGE_ALT;
      else if (p[6]) p = XPID_PAGE_BASE;
      rw(1'($urandom), 8'hA9 + 8'($urandom % 7), p, 8'($urandom));
      move(1'($urandom), 16'($urandom), 8'($urandom));
    end
    $display("test random done");
    do_reset();
    rw(0, 8'hAA, 8'h0F, 8'h00);
    rw(0, 8'hAD, 8'h0F, 8'h00);
    $display("test second reset done");
    wrap_up();
  end
endmodule
bind xpid_regs xpid_properties chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_sfr(i_sfr),
  .o_rdata(o_rdata), .o_hit(o_hit), .i_move(i_move), .o_xaddr(o_xaddr),
  .o_xram_index(o_xram_index), .o_xram_req(o_xram_req));
`default_nettype wire
